// ===== verilog/csg_cal_status.sv
`timescale 1ns/1ps
module csg_cal_status
  import csg_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Calibration activity levels
  input wire logic avg_power_zeroing,
  input wire logic chan_power_cal,
  input wire logic baseband_cal,
  input wire logic gen_level_cal,
  // Common commands
  input wire logic reset_cmd,
  input wire logic clear_status,
  // Register access
  input wire logic [2:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata_r,
  output logic reg_rvalid_r,
  // Error queue
  input wire logic err_push,
  input wire logic [CSG_QWIDTH-1:0] err_push_data,
  input wire logic err_pop,
  output logic [CSG_QWIDTH-1:0] err_pop_data_r,
  output logic err_queue_summary_r,
  // Output queue
  input wire logic out_push,
  input wire logic [CSG_QWIDTH-1:0] out_push_data,
  input wire logic out_pop,
  output logic [CSG_QWIDTH-1:0] out_pop_data_r,
  output logic out_queue_summary_r,
  // Higher-level status
  output logic [15:0] oper_status_r,
  output logic stb_oper_summary_r
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] cal_activity_rise_filter_r;
  logic [15:0] cal_activity_fall_filter_r;
  logic [15:0] cal_activity_event_r;
  logic [15:0] cal_activity_enable_r;
  // Last cycle's levels; edges are judged against these
  logic [15:0] cond_prev_r;
  logic oper_cal_en_r;
  logic [15:0] cal_activity_event_nxt;
  logic [15:0] rise_filter_nxt;
  logic [15:0] fall_filter_nxt;
  logic [15:0] enable_nxt;
  logic oper_cal_en_nxt;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire [15:0] cal_activity_condition = csg_used(
    (16'(avg_power_zeroing) << CSG_BIT_AVG_ZERO) |
    (16'(chan_power_cal) << CSG_BIT_CHAN_PWR) |
    (16'(baseband_cal) << CSG_BIT_BASEBAND) |
    (16'(gen_level_cal) << CSG_BIT_GEN_LEVEL));
  wire rd_cond = reg_rd && (reg_sel == CSG_SEL_COND);
  wire rd_rise = reg_rd && (reg_sel == CSG_SEL_RISE);
  wire rd_fall = reg_rd && (reg_sel == CSG_SEL_FALL);
  wire rd_event = reg_rd && (reg_sel == CSG_SEL_EVENT);
  wire rd_enable = reg_rd && (reg_sel == CSG_SEL_ENABLE);
  wire rd_oper_en = reg_rd && (reg_sel == CSG_SEL_OPER_EN);
  wire wr_rise = reg_wr && (reg_sel == CSG_SEL_RISE);
  wire wr_fall = reg_wr && (reg_sel == CSG_SEL_FALL);
  wire wr_enable = reg_wr && (reg_sel == CSG_SEL_ENABLE);
  wire wr_oper_en = reg_wr && (reg_sel == CSG_SEL_OPER_EN);

  // ----------------------------------------
  // Transition filters and event latch
  // ----------------------------------------
  wire [15:0] rise_seen = cal_activity_condition & ~cond_prev_r & cal_activity_rise_filter_r;
  wire [15:0] fall_seen = ~cal_activity_condition & cond_prev_r & cal_activity_fall_filter_r;
  wire [15:0] ev_set = csg_used(rise_seen | fall_seen);
  wire ev_clr = rd_event || clear_status;

  // Set wins over clear; a set bit simply stays set, nothing queues
  assign cal_activity_event_nxt = (ev_clr ? CSG_EVENT_RST : cal_activity_event_r)
                                  | ev_set;

  // Filters keep all 16 bits; only power-on, register writes and reset command touch them
  assign rise_filter_nxt = reset_cmd ? CSG_RISE_RST :
                           (wr_rise ? reg_wdata : cal_activity_rise_filter_r);
  assign fall_filter_nxt = reset_cmd ? CSG_FALL_RST :
                           (wr_fall ? reg_wdata : cal_activity_fall_filter_r);
  // Only explicit writes move the enables
  assign enable_nxt = wr_enable ? csg_used(reg_wdata) : cal_activity_enable_r;
  assign oper_cal_en_nxt = wr_oper_en ? reg_wdata[CSG_OPER_CAL_BIT] : oper_cal_en_r;

  // ----------------------------------------
  // Summary
  // ----------------------------------------
  wire summary_bit = |(cal_activity_event_r & cal_activity_enable_r);
  wire [15:0] oper_word = 16'(summary_bit) << CSG_OPER_CAL_BIT;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire [15:0] oper_en_word = 16'(oper_cal_en_r) << CSG_OPER_CAL_BIT;
  wire [15:0] rd_mux = rd_cond ? cal_activity_condition :
                       rd_rise ? cal_activity_rise_filter_r :
                       rd_fall ? cal_activity_fall_filter_r :
                       rd_event ? csg_used(cal_activity_event_r) :
                       rd_enable ? csg_used(cal_activity_enable_r) :
                       rd_oper_en ? oper_en_word :
                       16'h0000;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      cal_activity_rise_filter_r <= CSG_RISE_RST;
      cal_activity_fall_filter_r <= CSG_FALL_RST;
      cal_activity_event_r <= CSG_EVENT_RST;
      cal_activity_enable_r <= CSG_ENABLE_RST;
      oper_cal_en_r <= CSG_OPER_EN_RST;
      cond_prev_r <= 16'h0000;
    end else begin
      cal_activity_rise_filter_r <= rise_filter_nxt;
      cal_activity_fall_filter_r <= fall_filter_nxt;
      cal_activity_event_r <= cal_activity_event_nxt;
      cal_activity_enable_r <= enable_nxt;
      oper_cal_en_r <= oper_cal_en_nxt;
      cond_prev_r <= cal_activity_condition;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      reg_rdata_r <= 16'h0000;
      reg_rvalid_r <= 1'b0;
      oper_status_r <= 16'h0000;
      stb_oper_summary_r <= 1'b0;
    end else begin
      reg_rdata_r <= reg_rd ? rd_mux : 16'h0000;
      reg_rvalid_r <= reg_rd;
      oper_status_r <= oper_word;
      stb_oper_summary_r <= summary_bit && oper_cal_en_r;
    end
  end

  // ----------------------------------------
  // Status queues
  // ----------------------------------------
  csg_status_queue #(
    .CLEARABLE(1'b1)
  ) u_err_queue (
    .clock(clock),
    .resetn(resetn),
    .push(err_push),
    .push_data(err_push_data),
    .pop(err_pop),
    .pop_data_r(err_pop_data_r),
    .clear_status(clear_status),
    .nonempty_r(err_queue_summary_r)
  );

  // Output queue drains only by reading
  csg_status_queue #(
    .CLEARABLE(1'b0)
  ) u_out_queue (
    .clock(clock),
    .resetn(resetn),
    .push(out_push),
    .push_data(out_push_data),
    .pop(out_pop),
    .pop_data_r(out_pop_data_r),
    .clear_status(clear_status),
    .nonempty_r(out_queue_summary_r)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  chk_event_stays_set: assert property (
    !ev_clr |=> ((cal_activity_event_r & $past(cal_activity_event_r))
                 == $past(cal_activity_event_r)))
    else $error("event bit dropped without a clear");
  chk_read_clears_all: assert property (
    (rd_event && ev_set == 16'h0000) |=> (cal_activity_event_r == 16'h0000))
    else $error("event read did not clear the register");
  chk_race_keeps_set: assert property (
    ev_clr |=> (cal_activity_event_r == $past(ev_set)))
    else $error("transition lost under a clearing read");
  chk_rise_sets_event: assert property (
    (|(rise_seen & CSG_USED_MASK)) |=>
      ((cal_activity_event_r & $past(rise_seen)) == $past(rise_seen)))
    else $error("filtered rising edge did not set event");
  chk_fall_blocked_off: assert property (
    (ev_clr && (cal_activity_fall_filter_r & cond_prev_r) == 16'h0000 &&
     cal_activity_condition == 16'h0000 && cond_prev_r != 16'h0000) |=>
      (cal_activity_event_r == 16'h0000))
    else $error("unfiltered edge set an event");
  chk_unused_read_zero: assert property (
    ((cal_activity_event_r | cal_activity_enable_r) & ~CSG_USED_MASK) == 16'h0000)
    else $error("unused event or enable bit set");
  chk_summary_follows: assert property (
    1'b1 |=> (oper_status_r[CSG_OPER_CAL_BIT] == $past(summary_bit)))
    else $error("summary bit not the OR of enabled events");
  chk_enable_kept: assert property (
    ((clear_status || reg_rd) && !wr_enable) |=> $stable(cal_activity_enable_r))
    else $error("enable register changed by clear or read");
  chk_filter_reset: assert property (
    reset_cmd |=> (cal_activity_rise_filter_r == CSG_RISE_RST &&
                   cal_activity_fall_filter_r == CSG_FALL_RST))
    else $error("reset command left filters wrong");
  chk_filter_kept: assert property (
    (clear_status && !reset_cmd && !reg_wr) |=>
      ($stable(cal_activity_rise_filter_r) && $stable(cal_activity_fall_filter_r)))
    else $error("clear status moved a filter");
  chk_stb_gated: assert property (
    stb_oper_summary_r |-> ($past(oper_cal_en_r) && $past(summary_bit)))
    else $error("status byte bit without operation enable");
  chk_cond_live: assert property (
    rd_cond |=> (reg_rdata_r == $past(cal_activity_condition)))
    else $error("condition read not live");

  // ----------------------------------------
  // Register access checks
  // ----------------------------------------
  chk_enable_write_mask: assert property (
    wr_enable |=>
      (cal_activity_enable_r == csg_used($past(reg_wdata))))
    else $error("enable write kept an unused bit");
  chk_rise_write: assert property (
    (wr_rise && !reset_cmd) |=>
      (cal_activity_rise_filter_r == $past(reg_wdata)))
    else $error("rise filter write lost");
  chk_fall_write: assert property (
    (wr_fall && !reset_cmd) |=>
      (cal_activity_fall_filter_r == $past(reg_wdata)))
    else $error("fall filter write lost");
  chk_event_write_ignored: assert property (
    (reg_wr && reg_sel == CSG_SEL_EVENT && !ev_clr) |=>
      (cal_activity_event_r == ($past(cal_activity_event_r) | $past(ev_set))))
    else $error("event register took a write");
  chk_no_edge_no_event: assert property (
    (cal_activity_condition == cond_prev_r && !ev_clr) |=>
      $stable(cal_activity_event_r))
    else $error("event changed with no condition edge");
  chk_read_answer: assert property (
    reg_rd |=> reg_rvalid_r)
    else $error("read not answered");
  chk_idle_rdata_zero: assert property (
    !reg_rd |=>
      (!reg_rvalid_r && reg_rdata_r == 16'h0000))
    else $error("read data without a read");
  chk_unknown_sel_zero: assert property (
    (reg_rd && reg_sel > CSG_SEL_OPER_EN) |=>
      (reg_rdata_r == 16'h0000))
    else $error("unknown select read nonzero");
  chk_unused_bits_read: assert property (
    (reg_rd && (reg_sel == CSG_SEL_COND || reg_sel == CSG_SEL_EVENT ||
                reg_sel == CSG_SEL_ENABLE)) |=>
      ((reg_rdata_r & ~CSG_USED_MASK) == 16'h0000))
    else $error("unused bit read as one");
  chk_stb_follows_en: assert property (
    (summary_bit && oper_cal_en_r) |=>
      stb_oper_summary_r)
    else $error("enabled summary missed the status byte");
  chk_oper_word_alone: assert property (
    1'b1 |=>
      ((oper_status_r & ~(16'h0001 << CSG_OPER_CAL_BIT)) == 16'h0000))
    else $error("summary leaked outside its operation bit");
  chk_enable_read: assert property (
    rd_enable |=>
      (reg_rdata_r == $past(cal_activity_enable_r)))
    else $error("enable read wrong");
  chk_fall_sets_event: assert property (
    (|(fall_seen & CSG_USED_MASK)) |=>
      ((cal_activity_event_r & $past(fall_seen)) == $past(fall_seen)))
    else $error("filtered falling edge did not set event");

  cov_event_then_read: cover property (
    (ev_set != 16'h0000) ##[1:20] rd_event);
  cov_summary_to_stb: cover property (stb_oper_summary_r);
  cov_race_clear_set: cover property (ev_clr && ev_set != 16'h0000);
  cov_err_queue_cls: cover property (err_queue_summary_r ##1 clear_status);
  cov_fall_filtered: cover property (|fall_seen);

endmodule // csg_cal_status

// ===== verilog/csg_pkg.sv
package csg_pkg;

  // ----------------------------------------
  // Widths and depths
  // ----------------------------------------
  localparam int CSG_WIDTH = 16;
  localparam int CSG_QWIDTH = 8;
  localparam int CSG_QDEPTH = 8;
  localparam int CSG_QIDX_W = 3;
  localparam int CSG_QCNT_W = 4;
  localparam logic [3:0] CSG_QFULL = 4'h8;

  // ----------------------------------------
  // Bit positions of the calibrating group
  // ----------------------------------------
  localparam int CSG_BIT_AVG_ZERO = 0;
  localparam int CSG_BIT_CHAN_PWR = 1;
  localparam int CSG_BIT_BASEBAND = 2;
  localparam int CSG_BIT_GEN_LEVEL = 3;
  localparam logic [15:0] CSG_USED_MASK = 16'h000F;

  // Position of the calibrating summary inside the operation word
  localparam int CSG_OPER_CAL_BIT = 8;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] CSG_RISE_RST = 16'hFFFF;
  localparam logic [15:0] CSG_FALL_RST = 16'h0000;
  localparam logic [15:0] CSG_ENABLE_RST = 16'h0000;
  localparam logic [15:0] CSG_EVENT_RST = 16'h0000;
  localparam logic CSG_OPER_EN_RST = 1'b0;

  // ----------------------------------------
  // Register select codes
  // ----------------------------------------
  localparam logic [2:0] CSG_SEL_COND = 3'h0;
  localparam logic [2:0] CSG_SEL_RISE = 3'h1;
  localparam logic [2:0] CSG_SEL_FALL = 3'h2;
  localparam logic [2:0] CSG_SEL_EVENT = 3'h3;
  localparam logic [2:0] CSG_SEL_ENABLE = 3'h4;
  localparam logic [2:0] CSG_SEL_OPER_EN = 3'h5;

  function automatic logic [15:0] csg_used(input logic [15:0] v);
    return v & CSG_USED_MASK;
  endfunction

endpackage

// ===== verilog/csg_status_queue.sv
`timescale 1ns/1ps
module csg_status_queue
  import csg_pkg::*;
#(
  parameter bit CLEARABLE = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Fill side
  input wire logic push,
  input wire logic [CSG_QWIDTH-1:0] push_data,
  // Drain side
  input wire logic pop,
  output logic [CSG_QWIDTH-1:0] pop_data_r,
  // Clear and summary
  input wire logic clear_status,
  output logic nonempty_r
);

  logic [CSG_QWIDTH-1:0] mem_r [CSG_QDEPTH];
  logic [CSG_QIDX_W-1:0] wr_idx_r;
  logic [CSG_QIDX_W-1:0] rd_idx_r;
  logic [CSG_QCNT_W-1:0] count_r;
  logic [CSG_QCNT_W-1:0] count_nxt;
  logic [CSG_QIDX_W-1:0] rd_idx_nxt;
  wire do_clear = CLEARABLE && clear_status;
  wire do_pop = pop && (count_r != '0) && !do_clear;
  wire do_push = push && (count_r != CSG_QFULL);

  // A push racing a clear survives it unless the queue was full
  assign count_nxt = do_clear ? {3'b000, do_push} :
                     CSG_QCNT_W'(count_r + {3'b000, do_push} - {3'b000, do_pop});
  assign rd_idx_nxt = do_clear ? wr_idx_r :
                      (do_pop ? CSG_QIDX_W'(rd_idx_r + 3'h1) : rd_idx_r);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      wr_idx_r <= '0;
      rd_idx_r <= '0;
      count_r <= '0;
      nonempty_r <= 1'b0;
      pop_data_r <= '0;
    end else begin
      count_r <= count_nxt;
      rd_idx_r <= rd_idx_nxt;
      nonempty_r <= (count_nxt != '0);
      if (do_push) begin
        wr_idx_r <= CSG_QIDX_W'(wr_idx_r + 3'h1);
      end
      if (do_pop) begin
        pop_data_r <= mem_r[rd_idx_r];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (do_push) begin
      mem_r[wr_idx_r] <= push_data;
    end
  end

  chk_queue_summary_level: assert property (
    @(posedge clock) disable iff (!resetn) nonempty_r == (count_r != '0))
    else $error("queue summary disagrees with fill level");
  chk_cls_empties_queue: assert property (
    @(posedge clock) disable iff (!resetn)
    (clear_status && !push && count_r != '0) |=>
      (nonempty_r == (!CLEARABLE && !($past(pop) && $past(count_r) == 4'h1))))
    else $error("clear status mishandled queue");
  chk_push_beats_clear: assert property (
    @(posedge clock) disable iff (!resetn)
    (do_clear && do_push) |=> (count_r == 4'h1))
    else $error("push lost to a clear status");

endmodule // csg_status_queue

// ===== dv/csg_ctrl_model.sv
`timescale 1ns/1ps
module csg_ctrl_model
  import csg_pkg::*;
#(
  parameter int SEED = 97097
) (
  // Clock and enable
  input wire logic clock,
  input wire logic run,
  // Register port
  output logic [2:0] reg_sel,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata
);
  integer seed = SEED;
  logic [1:0] gap = 2'h0;
  logic [31:0] r;
  initial begin
    reg_sel = 3'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  // ----------------------------------------
  // Random queries, spaced by idle gaps
  // ----------------------------------------
  always @(posedge clock) begin
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_sel <= ~reg_sel;
    reg_wdata <= ~reg_wdata;
    if (gap != 2'h0) begin
      gap <= gap - 2'h1;
    end else if (run) begin
      r = $random(seed);
      reg_rd <= r[0] | r[7];
      reg_wr <= r[1] & ~r[7];
      // Event reads favoured so clearing reads race with edges often
      reg_sel <= r[7] ? CSG_SEL_EVENT : r[4:2];
      reg_wdata <= r[31:16];
      // Zero gap kept possible for back-to-back access
      gap <= r[6:5];
    end
  end
endmodule // csg_ctrl_model

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb
  import csg_pkg::*;
();
  logic clock, resetn, run, reset_cmd, clear_status;
  logic [3:0] cond;
  logic err_push, err_pop, out_push, out_pop;
  logic [7:0] err_push_data, out_push_data, err_pop_data_r, out_pop_data_r;
  logic [2:0] reg_sel;
  logic reg_wr, reg_rd, reg_rvalid_r, err_queue_summary_r, out_queue_summary_r;
  logic stb_oper_summary_r;
  logic [15:0] reg_wdata, reg_rdata_r, oper_status_r;
  integer seed = 97097;
  integer err_total = 0;
  integer samples_checked = 0;
  integer fill = 4;
  integer i;
  logic [31:0] r;
  logic [15:0] m_rise, m_fall, m_en, m_ev, m_rd, c, pv, set, rdv;
  logic [7:0] m_ed, m_od;
  logic [7:0] eq[$];
  logic [7:0] oq[$];
  logic [3:0] m_prev;
  logic m_oen, m_rv, m_sum, clr, last;
  int n;

  csg_ctrl_model i_csg_ctrl_model (.clock(clock), .run(run), .reg_sel(reg_sel),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  csg_cal_status i_csg_cal_status (.clock(clock), .resetn(resetn),
    .avg_power_zeroing(cond[0]), .chan_power_cal(cond[1]), .baseband_cal(cond[2]),
    .gen_level_cal(cond[3]), .reset_cmd(reset_cmd), .clear_status(clear_status),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r), .err_push(err_push),
    .err_push_data(err_push_data), .err_pop(err_pop), .err_pop_data_r(err_pop_data_r),
    .err_queue_summary_r(err_queue_summary_r), .out_push(out_push),
    .out_push_data(out_push_data), .out_pop(out_pop), .out_pop_data_r(out_pop_data_r),
    .out_queue_summary_r(out_queue_summary_r), .oper_status_r(oper_status_r),
    .stb_oper_summary_r(stb_oper_summary_r));

  task automatic chk(input logic ok, input string msg);
    samples_checked += 1;
    if (ok !== 1'b1) begin
      err_total += 1;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic report_and_stop;
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ----------------------------------------
  // Random stimulus; fill biases the queues
  // ----------------------------------------
  always @(posedge clock) begin
    r = $random(seed);
    cond <= (run && r[1:0] == 2'h0) ? cond ^ r[7:4] : cond;
    err_push <= run && r[18:16] < fill;
    err_pop <= run && r[21:19] >= fill;
    out_push <= run && r[24:22] < fill;
    out_pop <= run && r[27:25] >= fill;
    err_push_data <= r[31:24];
    out_push_data <= r[15:8];
    // Clears may meet error pushes; the push survives unless the queue was full
    clear_status <= run && r[12:8] == 5'h00;
    reset_cmd <= run && r[30:26] == 5'h1f;
  end

  // ----------------------------------------
  // Reference model, compared every cycle
  // ----------------------------------------
  always @(posedge clock) begin
    c = {12'h000, cond};
    pv = {12'h000, m_prev};
    if (!resetn) begin
      m_rise = CSG_RISE_RST;
      m_fall = CSG_FALL_RST;
      m_en = 16'h0000;
      m_ev = 16'h0000;
      m_prev = 4'h0;
      {m_oen, m_rv, m_sum, m_rd, m_ed, m_od, last} = '0;
      eq.delete();
      oq.delete();
    end else begin
      set = (c & ~pv & m_rise) | (~c & pv & m_fall);
      case (reg_sel)
        CSG_SEL_COND: rdv = c;
        CSG_SEL_RISE: rdv = m_rise;
        CSG_SEL_FALL: rdv = m_fall;
        CSG_SEL_EVENT: rdv = m_ev;
        CSG_SEL_ENABLE: rdv = m_en;
        CSG_SEL_OPER_EN: rdv = 16'(m_oen) << CSG_OPER_CAL_BIT;
        default: rdv = 16'h0000;
      endcase
      m_rv = reg_rd;
      m_rd = reg_rd ? rdv : 16'h0000;
      m_sum = |(m_ev & m_en);
      // Status byte bit uses the enable held before this edge's write
      last = m_sum & m_oen;
      clr = clear_status || (reg_rd && reg_sel == CSG_SEL_EVENT);
      m_ev = (clr ? 16'h0000 : m_ev) | set;
      m_prev = cond;
      if (reg_wr && reg_sel == CSG_SEL_RISE) m_rise = reg_wdata;
      if (reg_wr && reg_sel == CSG_SEL_FALL) m_fall = reg_wdata;
      if (reg_wr && reg_sel == CSG_SEL_ENABLE) m_en = reg_wdata & CSG_USED_MASK;
      if (reg_wr && reg_sel == CSG_SEL_OPER_EN) m_oen = reg_wdata[CSG_OPER_CAL_BIT];
      if (reset_cmd) begin
        m_rise = CSG_RISE_RST;
        m_fall = CSG_FALL_RST;
      end
      n = eq.size();
      if (clear_status) eq.delete();
      else if (err_pop && n > 0) m_ed = eq.pop_front();
      if (err_push && n < CSG_QDEPTH) eq.push_back(err_push_data);
      n = oq.size();
      if (out_pop && n > 0) m_od = oq.pop_front();
      if (out_push && n < CSG_QDEPTH) oq.push_back(out_push_data);
    end
    #1;
    chk(reg_rvalid_r === m_rv, "read valid");
    chk(reg_rdata_r === m_rd, "read data");
    chk(oper_status_r === (16'(m_sum) << CSG_OPER_CAL_BIT), "operation word");
    chk(stb_oper_summary_r === last, "status byte bit");
    chk(err_queue_summary_r === (eq.size() != 0), "error queue summary");
    chk(err_pop_data_r === m_ed, "error queue data");
    chk(out_queue_summary_r === (oq.size() != 0), "output queue summary");
    chk(out_pop_data_r === m_od, "output queue data");
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    run = 1'b0;
    cond = 4'h0;
    {reset_cmd, clear_status, err_push, err_pop, out_push, out_pop} = '0;
    {err_push_data, out_push_data} = '0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    run <= 1'b1;
    fill = 7;
    repeat (1500) @(posedge clock);
    fill = 1;
    repeat (1500) @(posedge clock);
    fill = 4;
    repeat (1500) @(posedge clock);
    run <= 1'b0;
    resetn <= 1'b0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    run <= 1'b1;
    fill = 6;
    repeat (1500) @(posedge clock);
    fill = 0;
    for (i = 0; i < 200 && out_queue_summary_r !== 1'b0; i++) @(posedge clock);
    if (out_queue_summary_r !== 1'b0) begin
      err_total += 1;
      $display("ERROR %0t output queue never drained", $time);
    end
    report_and_stop();
  end
endmodule // tb
